// ---- src/imc_defs.svh ----
`ifndef IMC_DEFS_SVH
`define IMC_DEFS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define IMC_ADDR_W 32
`define IMC_OFS_MODE 32'hffffe004
`define IMC_OFS_STATUS 32'hffffe100
`define IMC_OFS_MASK 32'hffffe104

// ----------------------------------------------------------------
// mode register field layout (source 2 in bits 23:16, source 3 in 31:24)
// ----------------------------------------------------------------
`define IMC_SRC2_LSB 16
`define IMC_SRC3_LSB 24
`define IMC_LVL_LSB 0
`define IMC_ROUTE_BIT 4
`define IMC_DET_LSB 5
`define IMC_MODE_RESET 32'h0000_0000
// writable mode bits; bits 3 and 7 of each source byte are reserved and read zero
`define IMC_MODE_WMASK 32'h7777_0000

// ----------------------------------------------------------------
// status / mask layout: bit 0 source 2, bit 1 source 3
// ----------------------------------------------------------------
`define IMC_NSRC 2

`endif

// ---- src/imc_pkg.sv ----
package imc_pkg;
    // detection kinds, encoded as in the mode field
    typedef enum logic [1:0]
    {
        IMC_DET_LOW = 2'h0,
        IMC_DET_HIGH = 2'h1,
        IMC_DET_FALL = 2'h2,
        IMC_DET_RISE = 2'h3
    } imc_detect_type;
endpackage

// ---- src/imc_slice.sv ----
`include "imc_defs.svh"

// Notes on behaviour
// RL1 - routing bit 0 keeps request off DMA trigger; 1 makes it a DMA start trigger
// RL2 - routing 0: level field 000 disables, 001..111 give CPU priority 1..7
// RL3 - routing 1: same field picks DMA channel 0..7
// RL4 - source 2 comes from pin b, source 3 from pin c, own fields each
// RL5 - source 3 routing bit acts exactly as source 2's
// RL6 - detect 00 low, 01 high, 10 fall, 11 rise; reserved read zero; reset zero
module imc_slice
    import imc_pkg::*;
#(
    parameter int NSRC = `IMC_NSRC
)
(
    input wire logic ref_clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic [31:0] addr, // register address
    input wire logic [31:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [31:0] rdata, // read data, cycle after rd
    input wire logic ext_irq_pin_b, // external pin feeding source 2
    input wire logic ext_irq_pin_c, // external pin feeding source 3
    output logic [NSRC-1:0] cpu_req, // request to cpu priority logic
    output logic [2:0] cpu_level_src2, // priority of source 2
    output logic [2:0] cpu_level_src3, // priority of source 3
    output logic [NSRC-1:0] dma_start, // dma start trigger, one cycle per edge, high every cycle a detected level holds
    output logic [2:0] dma_chan_src2, // dma channel for source 2
    output logic [2:0] dma_chan_src3, // dma channel for source 3
    output logic irq // level interrupt, unmasked status set
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (NSRC != `IMC_NSRC)
    begin : g_bad
        $error("imc_slice serves exactly two sources");
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [NSRC-1:0] sync1;
    logic [NSRC-1:0] sync2;
    logic [NSRC-1:0] pin_d; // delayed sample for edge detection
    logic [NSRC-1:0] next_sync1;
    logic [NSRC-1:0] next_sync2;
    logic [NSRC-1:0] next_pin_d;

    // only sync2 and pin_d are read by logic; sync1 feeds sync2 alone
    always_comb
    begin
        next_sync1 = {ext_irq_pin_c, ext_irq_pin_b}; // see RL4
        next_sync2 = sync1;
        next_pin_d = sync2;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            // pins idle high; resetting to one avoids a false low-level or edge event
            sync1 <= '1;
            sync2 <= '1;
            pin_d <= '1;
        end
        else
        begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            pin_d <= next_pin_d;
        end
    end

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [31:0] interrupt_mode_control_second;
    logic [NSRC-1:0] status;
    logic [NSRC-1:0] mask;
    logic [31:0] next_mode;
    logic [NSRC-1:0] next_status;
    logic [NSRC-1:0] next_mask;
    logic [31:0] next_rdata;
    logic [NSRC-1:0] event_hit;
    logic [NSRC-1:0] route;
    logic [2:0] lvl [NSRC];
    logic [1:0] det [NSRC];

    // per-source field extraction and detection
    for (genvar i = 0; i < NSRC; i++)
    begin : g_src
        localparam int BASE = (i == 0) ? `IMC_SRC2_LSB : `IMC_SRC3_LSB;
        assign route[i] = interrupt_mode_control_second[BASE+`IMC_ROUTE_BIT]; // see RL5
        assign lvl[i] = interrupt_mode_control_second[BASE+`IMC_LVL_LSB +: 3];
        assign det[i] = interrupt_mode_control_second[BASE+`IMC_DET_LSB +: 2];
        always_comb
        begin
            case (imc_detect_type'(det[i])) // see RL6
                IMC_DET_LOW: event_hit[i] = !sync2[i];
                IMC_DET_HIGH: event_hit[i] = sync2[i];
                IMC_DET_FALL: event_hit[i] = pin_d[i] && !sync2[i];
                IMC_DET_RISE: event_hit[i] = !pin_d[i] && sync2[i];
                default: event_hit[i] = 1'b0;
            endcase
        end
    end

    // register writes, sticky status, read-to-clear; set beats clear
    always_comb
    begin
        next_mode = interrupt_mode_control_second;
        next_mask = mask;
        next_status = status;
        next_rdata = '0;
        if (wr && addr == `IMC_OFS_MODE)
        begin
            next_mode = wdata & `IMC_MODE_WMASK; // reserved bits forced to zero; see RL6
        end
        if (wr && addr == `IMC_OFS_MASK)
        begin
            next_mask = wdata[NSRC-1:0];
        end
        if (rd)
        begin
            case (addr)
                `IMC_OFS_MODE: next_rdata = interrupt_mode_control_second;
                `IMC_OFS_STATUS: next_rdata = {30'h0, status};
                `IMC_OFS_MASK: next_rdata = {30'h0, mask};
                default: next_rdata = '0;
            endcase
            if (addr == `IMC_OFS_STATUS)
            begin
                next_status = '0;
            end
        end
        next_status = next_status | event_hit;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            interrupt_mode_control_second <= `IMC_MODE_RESET; // see RL6
            mask <= '0;
            status <= '0;
            rdata <= '0;
        end
        else
        begin
            interrupt_mode_control_second <= next_mode;
            mask <= next_mask;
            status <= next_status;
            rdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // routing to cpu or dma
    // ----------------------------------------------------------------
    logic [NSRC-1:0] next_cpu_req;
    logic [NSRC-1:0] next_dma_start;

    // level 000 disables the cpu path; dma path ignores the level meaning
    always_comb
    begin
        for (int k = 0; k < NSRC; k++)
        begin
            next_cpu_req[k] = event_hit[k] && !route[k] && (lvl[k] != 3'h0); // see RL2
            next_dma_start[k] = event_hit[k] && route[k]; // see RL1
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cpu_req <= '0;
            dma_start <= '0;
        end
        else
        begin
            cpu_req <= next_cpu_req;
            dma_start <= next_dma_start;
        end
    end

    // field carries priority or channel; the unused meaning reads zero
    assign cpu_level_src2 = route[0] ? 3'h0 : lvl[0]; // see RL2
    assign cpu_level_src3 = route[1] ? 3'h0 : lvl[1];
    assign dma_chan_src2 = route[0] ? lvl[0] : 3'h0; // see RL3
    assign dma_chan_src3 = route[1] ? lvl[1] : 3'h0;
    assign irq = |(status & mask);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    dma_off_cpu_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        dma_start[0] |-> $past(route[0])) // see RL1
        else $error("dma trigger from source 2 while routed to cpu");
    cpu_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        cpu_req[0] |-> $past(lvl[0]) != 3'h0 && !$past(route[0])) // see RL2
        else $error("cpu request with level zero or dma routing");
    chan_pass_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        route[1] |-> dma_chan_src3 == lvl[1] && cpu_level_src3 == 3'h0) // see RL3
        else $error("dma channel not taken from level field");
    pin_path_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        det[1] == 2'h1 && $past(det[1]) == 2'h1 && $past(ext_irq_pin_c, 2)
        |=> status[1]) // see RL4
        else $error("pin c high did not set source 3 status");
    src3_dma_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        dma_start[1] |-> !cpu_req[1] && $past(route[1])) // see RL5
        else $error("source 3 drove cpu and dma together");
    reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        interrupt_mode_control_second[15:0] == 16'h0
        && !interrupt_mode_control_second[31] && !interrupt_mode_control_second[27]
        && !interrupt_mode_control_second[23] && !interrupt_mode_control_second[19]) // see RL6
        else $error("reserved mode bits not zero");
    rise_detect_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        det[0] == 2'h3 && !pin_d[0] && sync2[0] |=> status[0]) // see RL6
        else $error("rising edge missed on source 2");
    irq_level_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (status & mask) != '0 |-> irq)
        else $error("interrupt low with unmasked status");

endmodule // imc_slice

// ---- dv/imc_far_end.sv ----
// ----------------------------------------
// far side: cpu priority logic and dma controller, counting what arrives
// ----------------------------------------
module imc_far_end
    import imc_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic [1:0] cpu_req, // priority requests
    input wire logic [1:0] dma_start, // dma start triggers
    output int cpu_cnt [2], // cpu requests taken per source
    output int dma_cnt [2] // dma starts taken per source
);
    timeunit 1ns;
    timeprecision 1ns;
    // each cycle high is one request, as the priority logic would take it
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cpu_cnt <= '{0, 0};
            dma_cnt <= '{0, 0};
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                cpu_cnt[i] <= cpu_cnt[i] + int'(cpu_req[i]);
                dma_cnt[i] <= dma_cnt[i] + int'(dma_start[i]);
            end
        end
    end
endmodule // imc_far_end

// ---- dv/interrupt_mode_control_slice_tb.sv ----
`include "imc_defs.svh"
module interrupt_mode_control_slice_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import imc_pkg::*;
    logic ref_clk = 0, resetn = 0, wr = 0, rd = 0, pin_b = 1, pin_c = 1, irq;
    logic [31:0] addr = 0, wdata = 0, rdata;
    logic [1:0] cpu_req, dma_start;
    logic [2:0] lvl2, lvl3, ch2, ch3;
    int cpu_cnt [2], dma_cnt [2];
    int err_count = 0, num_checks = 0;
    imc_slice DUT (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .ext_irq_pin_b(pin_b), .ext_irq_pin_c(pin_c),
        .cpu_req(cpu_req), .cpu_level_src2(lvl2), .cpu_level_src3(lvl3),
        .dma_start(dma_start), .dma_chan_src2(ch2), .dma_chan_src3(ch3), .irq(irq));
    imc_far_end far (.ref_clk(ref_clk), .resetn(resetn), .cpu_req(cpu_req),
        .dma_start(dma_start), .cpu_cnt(cpu_cnt), .dma_cnt(dma_cnt));
    // ----------------------------------------
    // clock, watchdog and shared tasks
    // ----------------------------------------
    initial
    begin
        forever #25 ref_clk = !ref_clk;
    end
    // whole run is under a thousand cycles, so this only trips on a hang
    initial
    begin
        #200000;
        err_count++;
        end_of_test();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        // one idle edge so a following write never reassigns wr in this step
        @(posedge ref_clk);
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [31:0] a, output logic [31:0] q);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 q = rdata;
        @(posedge ref_clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] q, v;
        logic [2:0] f;
        logic idle;
        int c0, d0, n;
        void'($urandom(32'hda51));
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rd_reg(`IMC_OFS_MODE, q);
        chk(q, 32'h0);
        rd_reg(`IMC_OFS_MASK, q);
        chk(q, 32'h0);
        wr_reg(32'hffffe0f0, 32'hffffffff);
        rd_reg(32'hffffe0f0, q);
        chk(q, 32'h0);
        v = $urandom;
        wr_reg(`IMC_OFS_MODE, v);
        rd_reg(`IMC_OFS_MODE, q);
        chk(q, v & 32'h7777_0000);
        $display("test registers done");
        // route 2 stands for cpu routing with the level field at zero
        for (int s = 0; s < 2; s++)
            for (int d = 0; d < 4; d++)
                for (int r = 0; r < 3; r++)
                begin
                    f = (r == 2) ? 3'h0 : (r == 1) ? 3'($urandom_range(7, 0)) : 3'($urandom_range(7, 1));
                    idle = (d == 0 || d == 2);
                    pin_b <= s ? 1'b1 : idle;
                    pin_c <= s ? idle : 1'b1;
                    repeat (4) @(posedge ref_clk);
                    v = (32'(f) | 32'(r == 1) << 4 | 32'(d) << 5) << (s ? 24 : 16);
                    wr_reg(`IMC_OFS_MODE, v);
                    wr_reg(`IMC_OFS_MASK, 32'h1 << s);
                    rd_reg(`IMC_OFS_MODE, q);
                    chk(q, v);
                    // pin moves under the old mode may have set stale status; drop them
                    rd_reg(`IMC_OFS_STATUS, q);
                    chk(irq, 1'b0);
                    c0 = cpu_cnt[s];
                    d0 = dma_cnt[s];
                    chk(s ? lvl3 : lvl2, (r == 0) ? f : 3'h0);
                    chk(s ? ch3 : ch2, (r == 1) ? f : 3'h0);
                    pin_b <= s ? 1'b1 : !idle;
                    pin_c <= s ? !idle : 1'b1;
                    repeat (4) @(posedge ref_clk);
                    pin_b <= s ? 1'b1 : idle;
                    pin_c <= s ? idle : 1'b1;
                    repeat (6) @(posedge ref_clk);
                    n = (d > 1) ? 1 : 4;
                    chk(32'(cpu_cnt[s] - c0), (r == 0) ? n : 0);
                    chk(32'(dma_cnt[s] - d0), (r == 1) ? n : 0);
                    chk(irq, 1'b1);
                    rd_reg(`IMC_OFS_STATUS, q);
                    chk(q, 32'h1 << s);
                    chk(irq, 1'b0);
                end
        $display("test detection and routing done");
        end_of_test();
    end
endmodule // interrupt_mode_control_slice_tb
